// *** nav_pulse_io_consts.svh ***
// timing counts, widths and field constants for the pulse and discrete section
`ifndef NAV_PULSE_IO_CONSTS_SVH
`define NAV_PULSE_IO_CONSTS_SVH
`define CLK_PERIOD_PS 5000
`define RTI_PERIOD_US 5000
`define RTI_CYCLES (`RTI_PERIOD_US * (1000000 / `CLK_PERIOD_PS))
`define TURN_OFF_DELAY_US 4500
`define TURN_OFF_CYCLES (`TURN_OFF_DELAY_US * (1000000 / `CLK_PERIOD_PS))
`define MIN_PULSE_US 5
`define MIN_PULSE_CYCLES ((`MIN_PULSE_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define SHUTDOWN_WINDOW_NS 100000
`define SHUTDOWN_CYCLES ((`SHUTDOWN_WINDOW_NS * 1000) / `CLK_PERIOD_PS)
`define VEL_CHANNELS 2
`define TORQUE_CHANNELS 3
`define Z_CHANNEL 2
`define IN_DISCRETES 26
`define OUT_DISCRETES 32
`define ACC_WIDTH 8
`define ACC_ZERO 8'h00
`define ACC_ONE 8'h01
`endif

// *** nav_pulse_io_pkg.sv ***
// types shared by the pulse and discrete section
package nav_pulse_io_pkg;
	typedef struct packed {
		logic pos;
		logic neg;
	} pulse_pair_t;
	typedef enum logic [1:0] {
		run_st = 2'b00,
		drain_st = 2'b01,
		halted_st = 2'b10
	} power_state_t;
	typedef struct packed {
		logic [31:0] set_mask;
		logic [31:0] clr_mask;
	} discrete_cmd_t;
endpackage

// *** vel_accumulator.sv ***
// signed up/down velocity pulse counter with read-and-clear
`timescale 1ns/1ps
`default_nettype none
`include "nav_pulse_io_consts.svh"
module vel_accumulator #(
	parameter int WIDTH = `ACC_WIDTH
) (
	input wire logic mclk_in,
	input wire logic nrst_in,
	input wire nav_pulse_io_pkg::pulse_pair_t pulse_in,
	input wire logic snap_in,
	output logic [WIDTH-1:0] count_out
);
	import nav_pulse_io_pkg::*;
	logic [WIDTH-1:0] acc_reg;
	logic prev_pos_reg;
	logic prev_neg_reg;
	logic up;
	logic dn;
	logic [WIDTH-1:0] step;
	// edge detection so each pulse counts once however long it stays high
	assign up = pulse_in.pos & ~prev_pos_reg;
	assign dn = pulse_in.neg & ~prev_neg_reg;
	assign step = (up && !dn) ? WIDTH'(`ACC_ONE) : (dn && !up) ? ~WIDTH'(`ACC_ZERO) : WIDTH'(`ACC_ZERO);
	always_ff @(posedge mclk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			prev_pos_reg <= 1'b0;
			prev_neg_reg <= 1'b0;
		end
		else
		begin
			prev_pos_reg <= pulse_in.pos;
			prev_neg_reg <= pulse_in.neg;
		end
	end
	// snap restarts from this cycle's step, so no pulse is lost on clear
	always_ff @(posedge mclk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			acc_reg <= WIDTH'(`ACC_ZERO);
			count_out <= WIDTH'(`ACC_ZERO);
		end
		else if (snap_in)
		begin
			count_out <= acc_reg;
			acc_reg <= step;
		end
		else
			acc_reg <= acc_reg + step;
	end
endmodule
`default_nettype wire

// *** nav_computer_pulse_io.sv ***
// pulse train, torquer command and discrete section of the navigation computer
// Behaviour
// - two velocity channels, positive and negative lines
// - count every pulse up to 10 kpps
// - snapshot and clear every 5 ms, lossless
// - three torquer channels, positive and negative lines
// - command pulses at fixed 200 per second
// - each command pulse at least 5 us, unless the halt or a change of torque_dir_in during the pulse cuts it short
// - turn-off only on Z, stops all
// - turn-off drives both Z lines together
// - turn-off 4500 us after turn-on
// - turn-on repeats every 5000 us
// - 26 input discretes sampled by software
// - 32 output discretes set/reset, held
// - shutdown finishes work then halts safely
// - shutdown completes within 0.1 ms
`timescale 1ns/1ps
`default_nettype none
`include "nav_pulse_io_consts.svh"
module nav_computer_pulse_io #(
	parameter int RTI_COUNT = `RTI_CYCLES,
	parameter int OFF_COUNT = `TURN_OFF_CYCLES,
	parameter int ACC_W = `ACC_WIDTH
) (
	input wire logic mclk_in,
	input wire logic nrst_in,
	input wire nav_pulse_io_pkg::pulse_pair_t [`VEL_CHANNELS-1:0] vel_pulse_in,
	input wire logic [`TORQUE_CHANNELS-1:0] torque_dir_in,
	input wire logic [`TORQUE_CHANNELS-1:0] torque_enable_in,
	input wire logic [`IN_DISCRETES-1:0] discrete_in,
	input wire logic discrete_sample_in,
	input wire nav_pulse_io_pkg::discrete_cmd_t discrete_cmd_in,
	input wire logic discrete_cmd_valid_in,
	input wire logic shutdown_in,
	input wire logic busy_in,
	output logic [ACC_W-1:0] vel_count0_out,
	output logic [ACC_W-1:0] vel_count1_out,
	output logic rti_out,
	output nav_pulse_io_pkg::pulse_pair_t [`TORQUE_CHANNELS-1:0] gyro_torquer_command_out,
	output logic [`IN_DISCRETES-1:0] discrete_sample_out,
	output logic [`OUT_DISCRETES-1:0] discrete_out,
	output logic halted_out
);
	import nav_pulse_io_pkg::*;
	localparam int PW = `MIN_PULSE_CYCLES;
	localparam int SD = `SHUTDOWN_CYCLES;
	logic [31:0] rti_cnt_reg;
	logic rti_tick;
	logic [31:0] pw_cnt_reg;
	logic on_active_reg;
	logic [`TORQUE_CHANNELS-1:0] ch_on_reg;
	logic off_active_reg;
	logic [ACC_W-1:0] cnt [`VEL_CHANNELS];
	power_state_t pwr_reg;
	logic [31:0] sd_cnt_reg;
	logic run_en;
	logic start_ok;
	logic armed_reg;
	logic halt_now;

	assign run_en = (pwr_reg != halted_st);
	// draining starts no new turn-on; a pulse pair in flight runs on only until the halt clears it
	assign start_ok = (pwr_reg == run_st);
	// forced exit keeps a margin before the supply drops
	assign halt_now = !busy_in || sd_cnt_reg == 32'(SD - 2);
	assign rti_tick = (rti_cnt_reg == 32'(RTI_COUNT - 1));

	// one timebase drives sampling and torquing; 10 ppm is the clock's own stability
	always_ff @(posedge mclk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			rti_cnt_reg <= 32'h0000_0000;
		else if (rti_tick)
			rti_cnt_reg <= 32'h0000_0000;
		else
			rti_cnt_reg <= rti_cnt_reg + 32'h0000_0001;
	end

	always_ff @(posedge mclk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			rti_out <= 1'b0;
		else
			rti_out <= rti_tick & run_en;
	end

	genvar g;
	generate
		for (g = 0; g < `VEL_CHANNELS; g++)
		begin : vel_ch
			vel_accumulator #(
				.WIDTH(ACC_W)
			) acc_u (
				.mclk_in(mclk_in),
				.nrst_in(nrst_in),
				.pulse_in(vel_pulse_in[g]),
				.snap_in(rti_tick),
				.count_out(cnt[g])
			);
		end
	endgenerate
	assign vel_count0_out = cnt[0];
	assign vel_count1_out = cnt[1];

	// turn-on at tick, turn-off OFF_COUNT later; both held for PW cycles
	// RTI_COUNT - OFF_COUNT must be at least PW, else the next tick cuts the turn-off
	always_ff @(posedge mclk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			pw_cnt_reg <= 32'h0000_0000;
			on_active_reg <= 1'b0;
			off_active_reg <= 1'b0;
			ch_on_reg <= '0;
			armed_reg <= 1'b0;
		end
		else if (!run_en)
		begin
			on_active_reg <= 1'b0;
			off_active_reg <= 1'b0;
			armed_reg <= 1'b0;
		end
		else if (rti_tick && start_ok)
		begin
			on_active_reg <= 1'b1;
			off_active_reg <= 1'b0;
			pw_cnt_reg <= 32'h0000_0000;
			ch_on_reg <= torque_enable_in;
			armed_reg <= 1'b1;
		end
		// turn-off only answers a turn-on that was really issued
		else if (rti_cnt_reg == 32'(OFF_COUNT - 1) && armed_reg)
		begin
			off_active_reg <= 1'b1;
			pw_cnt_reg <= 32'h0000_0000;
			armed_reg <= 1'b0;
		end
		else if (pw_cnt_reg == 32'(PW - 1))
		begin
			on_active_reg <= 1'b0;
			off_active_reg <= 1'b0;
			pw_cnt_reg <= pw_cnt_reg + 32'h0000_0001;
		end
		else if (on_active_reg || off_active_reg)
			pw_cnt_reg <= pw_cnt_reg + 32'h0000_0001;
	end

	generate
		for (g = 0; g < `TORQUE_CHANNELS; g++)
		begin : tq_ch
			always_ff @(posedge mclk_in or negedge nrst_in)
			begin
				if (!nrst_in)
					gyro_torquer_command_out[g] <= '0;
				// quiet from the cycle after the first halted cycle on
				else if (!run_en)
					gyro_torquer_command_out[g] <= '0;
				else if (off_active_reg && g == `Z_CHANNEL)
					gyro_torquer_command_out[g] <= '{pos: 1'b1, neg: 1'b1};
				else if (on_active_reg && ch_on_reg[g])
					gyro_torquer_command_out[g] <= '{pos: torque_dir_in[g],
						neg: ~torque_dir_in[g]};
				else
					gyro_torquer_command_out[g] <= '0;
			end
		end
	endgenerate

	always_ff @(posedge mclk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			discrete_sample_out <= '0;
		else if (discrete_sample_in)
			discrete_sample_out <= discrete_in;
	end

	// set wins over reset when both name the same bit
	always_ff @(posedge mclk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			discrete_out <= '0;
		else if (discrete_cmd_valid_in && run_en)
			discrete_out <= (discrete_out & ~discrete_cmd_in.clr_mask)
				| discrete_cmd_in.set_mask;
	end

	// drain waits for busy to fall but is cut off before supply dies
	always_ff @(posedge mclk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			pwr_reg <= run_st;
			sd_cnt_reg <= 32'h0000_0000;
			halted_out <= 1'b0;
		end
		else
		begin
			unique case (pwr_reg)
				run_st:
					if (shutdown_in)
					begin
						pwr_reg <= drain_st;
						sd_cnt_reg <= 32'h0000_0000;
					end
				drain_st:
				begin
					sd_cnt_reg <= sd_cnt_reg + 32'h0000_0001;
					if (halt_now)
					begin
						pwr_reg <= halted_st;
						halted_out <= 1'b1;
					end
				end
				halted_st:
					pwr_reg <= halted_st;
				default:
					pwr_reg <= halted_st;
			endcase
		end
	end
endmodule
`default_nettype wire

// *** nav_pulse_io_checker_assertions.sv ***
// bound assertion checker for the pulse io section
`timescale 1ns/1ps
`default_nettype none
`include "nav_pulse_io_consts.svh"
module nav_pulse_io_checker #(
	parameter int RTI_COUNT = 2000,
	parameter int OFF_COUNT = 1800
) (
	input wire logic mclk_in,
	input wire logic nrst_in,
	input wire logic shutdown_in,
	input wire logic busy_in,
	input wire logic discrete_cmd_valid_in,
	input wire logic rti_out,
	input wire nav_pulse_io_pkg::pulse_pair_t [2:0] gyro_torquer_command_out,
	input wire logic [31:0] discrete_out,
	input wire logic halted_out
);
	import nav_pulse_io_pkg::*;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!nrst_in);
	int c, w, s;
	logic seen;
	always_ff @(posedge mclk_in or negedge nrst_in)
		c <= !nrst_in || rti_out ? 0 : c + 1;
	// first tick after reset has no reference point
	always_ff @(posedge mclk_in or negedge nrst_in)
		seen <= nrst_in && (seen || rti_out);
	always_ff @(posedge mclk_in or negedge nrst_in)
		w <= !nrst_in || !gyro_torquer_command_out[0].pos ? 0 : w + 1;
	always_ff @(posedge mclk_in or negedge nrst_in)
		s <= !nrst_in || !shutdown_in || halted_out ? 0 : s + 1;
	a_rti_period: assert property (rti_out && seen |-> c == RTI_COUNT - 1)
		else $error("bad rti spacing");
	a_off_delay: assert property ($rose(&gyro_torquer_command_out[2]) |-> seen &&
		c >= OFF_COUNT - 3 && c <= OFF_COUNT) else $error("bad turn-off time");
	a_pulse_width: assert property ($fell(gyro_torquer_command_out[0].pos)
		|-> w >= `MIN_PULSE_CYCLES) else $error("pulse too short");
	a_halt_sticky: assert property (halted_out |=> halted_out) else $error("halt lost");
	a_halt_quiet: assert property (halted_out |=> gyro_torquer_command_out == '0)
		else $error("torquer active");
	a_halt_bound: assert property (s <= `SHUTDOWN_CYCLES + 4) else $error("halt late");
	a_halt_idle: assert property (shutdown_in && !busy_in |-> ##[1:4] halted_out)
		else $error("idle halt late");
	a_disc_change: assert property ($changed(discrete_out) |->
		$past(discrete_cmd_valid_in) && !$past(halted_out)) else $error("discrete moved");
endmodule
bind nav_computer_pulse_io nav_pulse_io_checker #(.RTI_COUNT(RTI_COUNT), .OFF_COUNT(OFF_COUNT))
	u_nav_pulse_io_checker (.mclk_in, .nrst_in, .shutdown_in, .busy_in,
	.discrete_cmd_valid_in, .rti_out, .gyro_torquer_command_out, .discrete_out, .halted_out);
`default_nettype wire

// *** vel_pulse_source.sv ***
// behavioural velocity pulse source on the gyro side
`timescale 1ns/1ps
`default_nettype none
module vel_pulse_source (
	input wire logic mclk_in,
	input wire logic start_in,
	input wire logic [5:0] np_in,
	input wire logic [5:0] nn_in,
	output nav_pulse_io_pkg::pulse_pair_t pulse_out
);
	import nav_pulse_io_pkg::*;
	int k = 255;
	initial pulse_out = '0;
	// pos and neg share cycles on purpose to hit cancellation
	always @(posedge mclk_in)
	begin
		k <= start_in ? 0 : k < 255 ? k + 1 : k;
		pulse_out.pos <= !k[0] && k / 2 < np_in;
		pulse_out.neg <= !k[0] && k / 2 < nn_in;
	end
endmodule
`default_nettype wire

// *** nav_computer_pulse_io_bench.sv ***
// self-checking bench for the pulse io section
`timescale 1ns/1ps
`default_nettype none
module nav_computer_pulse_io_bench;
	import nav_pulse_io_pkg::*;
	logic mclk_in = 0, nrst_in = 0, go = 0, smp = 0, cv = 0, sd = 0, busy = 0, rti, hlt;
	logic [2:0] dir = 0, en = 3'h7;
	logic [1:0][5:0] np = 0, nn = 0;
	logic [25:0] din = 0, so;
	logic [31:0] dx = 0, dout;
	logic [7:0] c0, c1;
	discrete_cmd_t cmd = '0;
	pulse_pair_t [1:0] vp;
	pulse_pair_t [2:0] tq;
	int seed = 16, n_fail = 0, compares = 0, i;
	initial forever #2.5 mclk_in = !mclk_in;
	vel_pulse_source u_vel_pulse_source[1:0] (.mclk_in, .start_in(go), .np_in(np), .nn_in(nn),
		.pulse_out(vp));
	// off-to-tick gap kept above the pulse width so no pulse is cut short
	nav_computer_pulse_io #(.RTI_COUNT(4000), .OFF_COUNT(2500)) u_nav_computer_pulse_io (
		.mclk_in, .nrst_in, .vel_pulse_in(vp), .torque_dir_in(dir), .torque_enable_in(en),
		.discrete_in(din), .discrete_sample_in(smp), .discrete_cmd_in(cmd),
		.discrete_cmd_valid_in(cv), .shutdown_in(sd), .busy_in(busy), .vel_count0_out(c0),
		.vel_count1_out(c1), .rti_out(rti), .gyro_torquer_command_out(tq),
		.discrete_sample_out(so), .discrete_out(dout), .halted_out(hlt));
	task automatic chk(input logic [31:0] g, e);
		compares++;
		if (g !== e)
		begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask
	task automatic sync;
		for (i = 0; i < 5000 && rti !== 1'b1; i++)
			cyc(1);
		chk(rti, 1'b1);
	endtask
	function automatic logic [5:0] r51;
		return 6'({$random(seed)} % 51);
	endfunction
	function automatic logic [7:0] net(input int j);
		return 8'(np[j]) - 8'(nn[j]);
	endfunction
	function automatic logic [5:0] on_exp(input logic [2:0] d, e);
		logic [5:0] v;
		v = '0;
		for (int j = 0; j < 3; j++)
			if (e[j])
				v[2 * j +: 2] = {d[j], !d[j]};
		return v;
	endfunction
	task automatic conclude;
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		cyc(12);
		nrst_in = 1;
		chk(dout, 0);
		sync();
		for (int t = 0; t < 5; t++)
		begin
			np = {r51(), t ? r51() : 6'h32};
			nn = {r51(), t == 1 ? 6'h32 : r51()};
			din = 26'($random(seed));
			cmd = {$random(seed), $random(seed)};
			dx = (dx & ~cmd.clr_mask) | cmd.set_mask;
			{go, smp, cv} = 3'h7;
			cyc(1);
			{go, smp, cv} = 3'h0;
			cyc(1);
			chk(so, din);
			chk(dout, dx);
			cyc(498);
			chk(tq, on_exp(dir, en));
			cyc(700);
			chk(tq, 0);
			{dir, en} = 6'($random(seed));
			cyc(1800);
			chk(tq, 6'h30);
			sync();
			chk(c0, net(0));
			chk(c1, net(1));
			$display("interval %0d done", t);
		end
		busy = 1;
		sd = 1;
		cyc(19990);
		chk(hlt, 0);
		cyc(20);
		chk(hlt, 1);
		cmd = '1;
		cv = 1;
		cyc(1);
		cv = 0;
		cyc(1);
		chk(dout, dx);
		chk(tq, 0);
		nrst_in = 0;
		cyc(2);
		nrst_in = 1;
		busy = 0;
		cyc(4);
		chk(hlt, 1);
		$display("shutdown done");
		conclude();
	end
	initial
	begin
		#300000;
		n_fail++;
		conclude();
	end
endmodule
`default_nettype wire
